// ==== hdl/cda_consts.vh ====
// constants for the controller data area store
`ifndef CDA_CONSTS_VH
`define CDA_CONSTS_VH
`define CDA_HOLD_WORDS      100
`define CDA_HOLD_AW         7
`define CDA_TMC_COUNT       512
`define CDA_TMC_AW          9
`define CDA_LINK_WORDS      64
`define CDA_LINK_AW         6
`define CDA_BRANCH_BITS     8
`define CDA_BLOCK_WORDS     128
`define CDA_BLOCK_MAX_SMALL 16'h0999
`define CDA_BLOCK_MAX_LARGE 16'h1999
`define CDA_PROG_8K         2'h0
`define CDA_PROG_16K        2'h1
`define CDA_PROG_24K        2'h2
`define CDA_PROG_32K        2'h3
`define CDA_AREA_HOLD       2'h0
`define CDA_AREA_TMC        2'h1
`define CDA_AREA_LINK       2'h2
`define CDA_AREA_BRANCH     2'h3
`endif

// ==== hdl/cda_ram.v ====
// single-port word memory with registered read data
module cda_ram #(
  parameter DW    = 16,
  parameter AW    = 7,
  parameter DEPTH = 100
) (
  core_clk,
  we,
  addr,
  wdata,
  rdata
);
  input  wire          core_clk;
  input  wire          we;
  input  wire [AW-1:0] addr;
  input  wire [DW-1:0] wdata;
  output reg  [DW-1:0] rdata;

  reg [DW-1:0] mem [0:DEPTH-1];

  // no reset on contents: they survive resets and stops
  always @(posedge core_clk) begin
    if (we)
      mem[addr] <= wdata;
    rdata <= mem[addr];
  end
endmodule // cda_ram

// ==== hdl/cda_blkchk.v ====
// file storage block number check: bcd, range and unit presence
`include "cda_consts.vh"
module cda_blkchk (
  blk_num,
  unit_mounted,
  unit_large,
  blk_ok
);
  input  wire [15:0] blk_num;
  input  wire        unit_mounted;
  input  wire        unit_large;
  output wire        blk_ok;

  wire bcd_ok;
  wire [15:0] limit;

  // every digit must be a decimal digit
  assign bcd_ok = (blk_num[3:0] < 4'ha) && (blk_num[7:4] < 4'ha) &&
                  (blk_num[11:8] < 4'ha) && (blk_num[15:12] < 4'ha);
  assign limit  = unit_large ? `CDA_BLOCK_MAX_LARGE : `CDA_BLOCK_MAX_SMALL;
  // bcd compares like binary once digits are valid
  assign blk_ok = unit_mounted && bcd_ok && (blk_num <= limit);
endmodule // cda_blkchk

// ==== hdl/cda_store.v ====
// controller data area store: holding, timer/counter, link, branch and file gate
//
// How it works
// - holding area word 0..99, bit 0..15 per word, unrestricted bit use
// - holding area survives mode change, power loss and stop
// - timer/counter numbers 0..511 hold flag, set value, present value
// - defining one timer/counter number twice raises a program check error
// - bit access to a timer/counter number returns its completion flag
// - word read of a timer/counter number returns its present value; word writes leave it unchanged
// - set values kept through power interruptions
// - timer present values cleared at run start and interlock reset
// - counter present values kept at run start and interlock reset
// - only own allocated link words writable; peer copies read-only
// - link area word 0..63, bit 0..15, unused words as work storage
// - link area cleared on power loss, program mode entry, interlock reset
// - program memory 8K, 16K, 24K or 32K words per fitted unit
// - file storage exists only when its unit is mounted
// - file storage accessed in whole 128-word blocks, bcd block numbers
// - block numbers 0000..0999 or 0000..1999 by unit model
// - file storage kept through power loss and stop
// - eight branch bits for load and output only, no reuse per block
`include "cda_consts.vh"
module cda_store (
  core_clk,
  rstn,
  power_up,
  run_start,
  prog_mode_entry,
  il_reset,
  acc_valid,
  acc_area,
  acc_write,
  acc_is_bit,
  acc_word,
  acc_bit,
  acc_wdata,
  acc_is_load_out,
  rd_valid,
  rd_data,
  acc_error,
  link_own_mask,
  link_peer_we,
  link_peer_word,
  link_peer_data,
  def_valid,
  def_num,
  def_is_counter,
  def_clear,
  check_error,
  setval_we,
  setval_num,
  setval_data,
  setval_rdata,
  presval_we,
  presval_num,
  presval_data,
  done_set,
  branch_block_start,
  mem_unit_type,
  prog_words,
  file_unit_mounted,
  file_unit_large,
  file_req,
  file_blk,
  file_ok,
  file_base,
  file_len
);
  input  wire        core_clk;
  input  wire        rstn;
  input  wire        power_up;
  input  wire        run_start;
  input  wire        prog_mode_entry;
  input  wire        il_reset;
  input  wire        acc_valid;
  input  wire [1:0]  acc_area;
  input  wire        acc_write;
  input  wire        acc_is_bit;
  input  wire [8:0]  acc_word;
  input  wire [3:0]  acc_bit;
  input  wire [15:0] acc_wdata;
  input  wire        acc_is_load_out;
  output reg         rd_valid;
  output reg  [15:0] rd_data;
  output reg         acc_error;
  input  wire [63:0] link_own_mask;
  input  wire        link_peer_we;
  input  wire [5:0]  link_peer_word;
  input  wire [15:0] link_peer_data;
  input  wire        def_valid;
  input  wire [8:0]  def_num;
  input  wire        def_is_counter;
  input  wire        def_clear;
  output reg         check_error;
  input  wire        setval_we;
  input  wire [8:0]  setval_num;
  input  wire [15:0] setval_data;
  output wire [15:0] setval_rdata;
  input  wire        presval_we;
  input  wire [8:0]  presval_num;
  input  wire [15:0] presval_data;
  input  wire        done_set;
  input  wire        branch_block_start;
  input  wire [1:0]  mem_unit_type;
  output reg  [15:0] prog_words;
  input  wire        file_unit_mounted;
  input  wire        file_unit_large;
  input  wire        file_req;
  input  wire [15:0] file_blk;
  output reg         file_ok;
  output reg  [31:0] file_base;
  output reg  [7:0]  file_len;

  // reset synchroniser
  reg rst_s1_q;
  reg rst_s2_q;
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  wire rst_n = rst_s2_q;

  // decode of the access
  wire hold_sel   = acc_valid && acc_area == `CDA_AREA_HOLD;
  wire tmc_sel    = acc_valid && acc_area == `CDA_AREA_TMC;
  wire link_sel   = acc_valid && acc_area == `CDA_AREA_LINK;
  wire branch_sel = acc_valid && acc_area == `CDA_AREA_BRANCH;
  wire hold_range = acc_word < `CDA_HOLD_WORDS;
  wire link_range = acc_word < `CDA_LINK_WORDS;
  wire br_range   = acc_is_bit && acc_word < `CDA_BRANCH_BITS;
  wire [5:0] lw   = acc_word[5:0];

  // holding area memory, never cleared by any mode event
  wire [15:0] hold_rd;
  wire        hold_we = hold_sel && acc_write && hold_range;
  reg  [15:0] hold_wd;
  reg         hold_rmw_q;
  reg  [6:0]  hold_addr_q;
  reg  [3:0]  hold_bit_q;
  reg         hold_bitval_q;
  // bit writes become read-modify-write over two cycles
  wire        hold_bit_wr = hold_we && acc_is_bit;
  always @* begin
    hold_wd = hold_rd;
    hold_wd[hold_bit_q] = hold_bitval_q;
  end
  cda_ram #(.DW(16), .AW(`CDA_HOLD_AW), .DEPTH(`CDA_HOLD_WORDS)) u_hold (
    .core_clk (core_clk),
    .we       (hold_rmw_q || (hold_we && !acc_is_bit)),
    .addr     (hold_rmw_q ? hold_addr_q : acc_word[6:0]),
    .wdata    (hold_rmw_q ? hold_wd : acc_wdata),
    .rdata    (hold_rd)
  );
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_rmw_q    <= 1'b0;
      hold_addr_q   <= 7'h00;
      hold_bit_q    <= 4'h0;
      hold_bitval_q <= 1'b0;
    end else begin
      hold_rmw_q    <= hold_bit_wr;
      hold_addr_q   <= acc_word[6:0];
      hold_bit_q    <= acc_bit;
      hold_bitval_q <= acc_wdata[0];
    end
  end

  // set values: kept in memory without reset
  cda_ram #(.DW(16), .AW(`CDA_TMC_AW), .DEPTH(`CDA_TMC_COUNT)) u_setval (
    .core_clk (core_clk),
    .we       (setval_we),
    .addr     (setval_num),
    .wdata    (setval_data),
    .rdata    (setval_rdata)
  );

  // timer/counter per-number state in flops so bulk clears take one cycle;
  // the price is area, traded for single-cycle mode clears
  reg [15:0] presval_q [0:`CDA_TMC_COUNT-1];
  reg        done_q    [0:`CDA_TMC_COUNT-1];
  reg        kind_q    [0:`CDA_TMC_COUNT-1];
  reg        def_q     [0:`CDA_TMC_COUNT-1];
  wire       tmc_clear = run_start || il_reset;
  genvar g;
  generate
    for (g = 0; g < `CDA_TMC_COUNT; g = g + 1) begin : g_tmc
      always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          presval_q[g] <= 16'h0000;
          done_q[g]    <= 1'b0;
          kind_q[g]    <= 1'b0;
          def_q[g]     <= 1'b0;
        end else begin
          if (def_clear)
            def_q[g] <= 1'b0;
          // a definition in the clear cycle still counts: set wins
          if (def_valid && def_num == g) begin
            def_q[g] <= 1'b1;
            if (def_clear || !def_q[g])
              kind_q[g] <= def_is_counter; // a repeat keeps the first kind
          end
          if (presval_we && presval_num == g) begin
            presval_q[g] <= presval_data;
            done_q[g]    <= done_set;
          end else if (tmc_clear && !kind_q[g]) begin
            presval_q[g] <= 16'h0000;
            done_q[g]    <= 1'b0;
          end // counters fall through untouched
        end
      end
    end
  endgenerate

  // duplicate definition check
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      check_error <= 1'b0;
    else if (def_valid && def_q[def_num])
      check_error <= 1'b1;
    else if (def_clear)
      check_error <= 1'b0;
  end

  // link area: own words from local writes, others from peers only
  reg [15:0] link_q [0:`CDA_LINK_WORDS-1];
  wire link_clear = power_up || prog_mode_entry || il_reset;
  wire link_wr_ok = link_sel && acc_write && link_range && link_own_mask[lw];
  generate
    for (g = 0; g < `CDA_LINK_WORDS; g = g + 1) begin : g_link
      always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n)
          link_q[g] <= 16'h0000;
        else if (link_clear)
          link_q[g] <= 16'h0000;
        else if (link_wr_ok && lw == g) begin
          if (acc_is_bit)
            link_q[g][acc_bit] <= acc_wdata[0];
          else
            link_q[g] <= acc_wdata;
        end else if (link_peer_we && link_peer_word == g && !link_own_mask[g])
          link_q[g] <= link_peer_data;
      end
    end
  endgenerate

  // temporary branch bits with per-block use tracking
  reg [7:0] br_q;
  reg [7:0] br_used_q;
  wire [2:0] bi = acc_word[2:0];
  wire br_ok = branch_sel && br_range && acc_is_load_out &&
               !(acc_write && br_used_q[bi]);
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      br_q      <= 8'h00;
      br_used_q <= 8'h00;
    end else begin
      if (br_ok && acc_write)
        br_q[bi] <= acc_wdata[0];
      if (branch_block_start)
        br_used_q <= 8'h00;
      if (br_ok && acc_write)
        br_used_q[bi] <= 1'b1; // later assignment wins
    end
  end

  // errors from decode, resolved in the access cycle
  reg err_d;
  always @* begin
    err_d = 1'b0;
    if (hold_sel && !hold_range)
      err_d = 1'b1;
    if (tmc_sel && (acc_write && acc_is_bit))
      err_d = 1'b1;
    if (link_sel && (!link_range || (acc_write && !link_own_mask[lw])))
      err_d = 1'b1;
    if (branch_sel && !br_ok)
      err_d = 1'b1;
  end

  // read path; holding reads arrive one cycle later from the ram
  reg        hold_rd_q;
  reg        hold_isbit_q;
  reg [3:0]  hold_rbit_q;
  reg [15:0] imm_q;
  reg        imm_v_q;
  wire [8:0] tn = acc_word;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_rd_q    <= 1'b0;
      hold_isbit_q <= 1'b0;
      hold_rbit_q  <= 4'h0;
      imm_q        <= 16'h0000;
      imm_v_q      <= 1'b0;
      acc_error    <= 1'b0;
    end else begin
      hold_rd_q    <= hold_sel && !acc_write && hold_range;
      hold_isbit_q <= acc_is_bit;
      hold_rbit_q  <= acc_bit;
      acc_error    <= err_d;
      imm_v_q      <= !acc_write && !err_d && (tmc_sel || link_sel || branch_sel);
      if (tmc_sel)
        imm_q <= acc_is_bit ? {15'h0000, done_q[tn]} : presval_q[tn];
      else if (link_sel)
        imm_q <= acc_is_bit ? {15'h0000, link_q[lw][acc_bit]} : link_q[lw];
      else
        imm_q <= {15'h0000, br_q[bi]};
    end
  end

  // align both read paths to two cycles after the request
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_valid <= 1'b0;
      rd_data  <= 16'h0000;
    end else begin
      rd_valid <= hold_rd_q || imm_v_q;
      if (hold_rd_q)
        rd_data <= hold_isbit_q ? {15'h0000, hold_rd[hold_rbit_q]} : hold_rd;
      else
        rd_data <= imm_q;
    end
  end
  // both read paths answer on the same cycle, whatever the area
  // program memory size from fitted unit type
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      prog_words <= 16'h2000;
    else begin
      case (mem_unit_type)
        `CDA_PROG_8K:  prog_words <= 16'h2000;
        `CDA_PROG_16K: prog_words <= 16'h4000;
        `CDA_PROG_24K: prog_words <= 16'h6000;
        `CDA_PROG_32K: prog_words <= 16'h8000;
        default:       prog_words <= 16'h2000;
      endcase
    end
  end

  // file storage gate: storage itself lives in the unit, kept by it
  wire blk_ok;
  cda_blkchk u_blkchk (
    .blk_num      (file_blk),
    .unit_mounted (file_unit_mounted),
    .unit_large   (file_unit_large),
    .blk_ok       (blk_ok)
  );
  wire [31:0] blk_bin = file_blk[15:12] * 32'd1000 + file_blk[11:8] * 32'd100 +
                        file_blk[7:4] * 32'd10 + {28'h0000000, file_blk[3:0]};
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      file_ok   <= 1'b0;
      file_base <= 32'h00000000;
      file_len  <= 8'h00;
    end else begin
      file_ok   <= file_req && blk_ok;
      file_base <= {blk_bin[24:0], 7'h00};
      file_len  <= (file_req && blk_ok) ? 8'h80 : 8'h00;
    end
  end
endmodule // cda_store

// ==== bench/cda_store_properties.sv ====
// port checker for the data area store
module cda_store_chk (
  input wire        core_clk,
  input wire        rstn,
  input wire        acc_valid,
  input wire [1:0]  acc_area,
  input wire        acc_write,
  input wire        acc_is_bit,
  input wire [8:0]  acc_word,
  input wire        acc_is_load_out,
  input wire        acc_error,
  input wire        rd_valid,
  input wire [63:0] link_own_mask,
  input wire        def_clear,
  input wire        check_error,
  input wire        file_unit_mounted,
  input wire        file_req,
  input wire        file_ok,
  input wire [31:0] file_base,
  input wire [7:0]  file_len
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  a_hold_range: assert property (
    acc_valid && acc_area == 2'h0 && acc_word > 9'h063 |=> acc_error) else $error("hold range");
  a_link_range: assert property (
    acc_valid && acc_area == 2'h2 && acc_word > 9'h03f |=> acc_error) else $error("link range");
  a_link_own: assert property (
    acc_valid && acc_area == 2'h2 && acc_write && acc_word[8:6] == 3'h0
    && !link_own_mask[acc_word[5:0]] |=> acc_error) else $error("peer word written");
  a_tmc_bitwr: assert property (
    acc_valid && acc_area == 2'h1 && acc_write && acc_is_bit |=> acc_error)
    else $error("timer/counter bit write taken");
  a_branch_bad: assert property (
    acc_valid && acc_area == 2'h3 && (acc_word > 9'h007 || !acc_is_load_out) |=> acc_error)
    else $error("branch misuse taken");
  // a legal holding read answers two cycles on
  a_read_answer: assert property (
    acc_valid && !acc_write && acc_area == 2'h0 && acc_word < 9'h064
    |=> !acc_error ##1 rd_valid) else $error("hold read lost");
  a_file_gate: assert property (
    file_req && !file_unit_mounted |=> !file_ok) else $error("file without unit");
  a_file_shape: assert property (
    file_ok |-> file_len == 8'h80 && file_base[6:0] == 7'h00) else $error("file not a block");
  a_check_sticky: assert property (
    check_error && !def_clear |=> check_error) else $error("check error dropped");
endmodule // cda_store_chk

bind cda_store cda_store_chk cda_store_chk_i (.*);

// ==== bench/cda_peer.sv ====
// far side model: a linked peer and the file storage unit
module cda_peer (
  input  logic        core_clk,
  output logic        link_peer_we,
  output logic [5:0]  link_peer_word,
  output logic [15:0] link_peer_data,
  output logic        file_unit_mounted,
  output logic        file_unit_large
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {link_peer_we, link_peer_word, file_unit_mounted, file_unit_large} = '0;
    link_peer_data = 16'h5a5a;
  end
  // a peer copies only its own write words across
  task copy_in(input logic [5:0] w, input logic [15:0] d);
    @(posedge core_clk);
    link_peer_we <= 1'b1;
    link_peer_word <= w;
    link_peer_data <= d;
    @(posedge core_clk);
    link_peer_we <= 1'b0;
    link_peer_data <= ~d; // released lines must not look valid
  endtask
  // presence and model select the legal block range
  task mount_unit(input logic m, input logic l);
    @(posedge core_clk);
    file_unit_mounted <= m;
    file_unit_large <= l;
  endtask
endmodule // cda_peer

// ==== bench/testbench.sv ====
// self-checking bench for the data area store
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk, rstn, acc_valid, acc_write, acc_is_bit, acc_is_load_out, rd_valid;
  logic        acc_error, def_valid, def_is_counter, def_clear, check_error, av_q;
  logic        setval_we, presval_we;
  logic        done_set, branch_block_start, file_req, file_ok, link_peer_we, fr_q;
  logic        file_unit_mounted, file_unit_large, power_up, run_start, prog_mode_entry;
  logic        il_reset;
  logic [1:0]  acc_area, mem_unit_type;
  logic [3:0]  acc_bit;
  logic [5:0]  link_peer_word, ctl;
  logic [7:0]  file_len;
  logic [8:0]  acc_word, def_num, setval_num, presval_num;
  logic [15:0] acc_wdata, rd_data, link_peer_data, prog_words;
  logic [15:0] setval_data, setval_rdata, presval_data;
  logic [15:0] file_blk, hd, ld, pd, dp;
  logic [31:0] file_base, rng_q;
  logic [40:0] fe;
  logic [63:0] link_own_mask;
  logic [15:0] rq[$];
  logic [40:0] fq[$];
  logic        eq[$];
  int          mismatches = 0, checked = 0, cyc = 0;

  cda_store cda_store_i (.*);
  cda_peer cda_peer_i (.*);
  assign {def_clear, branch_block_start, power_up, run_start, prog_mode_entry, il_reset} = ctl;

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  function logic [15:0] rnd();
    rng_q = rng_q ^ (rng_q << 13);
    rng_q = rng_q ^ (rng_q >> 17);
    rng_q = rng_q ^ (rng_q << 5);
    return rng_q[15:0];
  endfunction

  task check(input logic [40:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task give_verdict;
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // one request, held up to its taking edge only
  task acc(input logic [1:0] ar, input logic wr, bt, input logic [8:0] wd,
           input logic [3:0] bi, input logic [15:0] d, input logic e = 1'b0);
    eq.push_back(e);
    @(posedge core_clk);
    acc_valid <= 1'b1;
    {acc_area, acc_write, acc_is_bit, acc_word, acc_bit, acc_wdata} <= {ar, wr, bt, wd, bi, d};
    @(posedge core_clk);
    acc_valid <= 1'b0;
  endtask

  task rd(input logic [1:0] ar, input logic bt, input logic [8:0] wd, input logic [15:0] e);
    rq.push_back(e);
    acc(ar, 1'b0, bt, wd, 4'h0, rnd());
  endtask

  task pulse(input logic [5:0] m);
    @(posedge core_clk);
    ctl <= m;
    @(posedge core_clk);
    ctl <= 6'h00;
  endtask

  task def(input logic [8:0] n, input logic c);
    @(posedge core_clk);
    {def_valid, def_num, def_is_counter} <= {1'b1, n, c};
    @(posedge core_clk);
    def_valid <= 1'b0;
  endtask

  task pvw(input logic [8:0] n, input logic [15:0] d);
    @(posedge core_clk);
    {presval_we, done_set, presval_num, presval_data} <= {2'h3, n, d};
    @(posedge core_clk);
    {presval_we, done_set} <= 2'h0;
  endtask

  task fil(input logic [15:0] b, input logic ok);
    @(posedge core_clk);
    {file_req, file_blk} <= {1'b1, b};
    fq.push_back({ok, (b[15:12] * 1000 + b[11:8] * 100 + b[7:4] * 10 + b[3:0]) * 128, 8'h80});
    @(posedge core_clk);
    file_req <= 1'b0;
  endtask

  // results compared in arrival order against the oldest note; hang guard
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    fr_q <= file_req;
    av_q <= acc_valid;
    if (av_q === 1'b1) check(acc_error, eq.pop_front());
    if (rd_valid === 1'b1) check(rd_data, rq.pop_front());
    if (fr_q === 1'b1) begin
      fe = fq.pop_front();
      check(file_ok, fe[40]);
      if (fe[40]) check({file_ok, file_base, file_len}, fe);
      else check(file_len, 8'h00);
    end
    // the guard stands last so nothing runs after the verdict
    if (cyc == 3000) begin
      mismatches++;
      give_verdict;
    end
  end

  initial begin
    rng_q = 32'he720ffc3;
    {rstn, acc_valid, acc_write, acc_is_bit, def_valid, def_is_counter} = '0;
    {setval_we, presval_we} = '0;
    {done_set, file_req, fr_q, acc_area, mem_unit_type, acc_bit, ctl, acc_word} = '0;
    {def_num, setval_num, presval_num, acc_wdata, setval_data, presval_data, file_blk} = '0;
    acc_is_load_out = 1'b1;
    link_own_mask = 64'h0000_0000_0000_0400;
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge core_clk);
    // holding words: top word, a high and a low bit, one word past the end
    hd = rnd();
    acc(2'h0, 1'b1, 1'b0, 9'h063, 4'h0, hd);
    acc(2'h0, 1'b1, 1'b0, 9'h005, 4'h0, 16'h0000);
    acc(2'h0, 1'b1, 1'b1, 9'h005, 4'hf, 16'h0001);
    acc(2'h0, 1'b1, 1'b1, 9'h005, 4'h0, 16'h0001);
    acc(2'h0, 1'b1, 1'b0, 9'h064, 4'h0, 16'hffff, 1'b1);
    rd(2'h0, 1'b1, 9'h005, 16'h0001);
    rd(2'h0, 1'b0, 9'h005, 16'h8001);
    // own link word writable, peer copy locked, word past the end
    ld = rnd();
    dp = rnd();
    acc(2'h2, 1'b1, 1'b0, 9'h00a, 4'h0, ld);
    cda_peer_i.copy_in(6'h14, dp);
    acc(2'h2, 1'b1, 1'b0, 9'h014, 4'h0, ~dp, 1'b1);
    acc(2'h2, 1'b1, 1'b0, 9'h040, 4'h0, ld, 1'b1);
    rd(2'h2, 1'b0, 9'h00a, ld);
    acc(2'h2, 1'b1, 1'b1, 9'h00a, 4'h0, {15'h0000, ~ld[0]});
    rd(2'h2, 1'b1, 9'h00a, {15'h0000, ~ld[0]});
    rd(2'h2, 1'b0, 9'h014, dp);
    // timer 3, counter 511, set value 7
    pd = rnd();
    def(9'h003, 1'b0);
    def(9'h1ff, 1'b1);
    pvw(9'h003, 16'h1234);
    pvw(9'h1ff, pd);
    acc(2'h1, 1'b1, 1'b1, 9'h003, 4'h0, 16'h0000, 1'b1);
    rd(2'h1, 1'b0, 9'h1ff, pd);
    rd(2'h1, 1'b1, 9'h1ff, 16'h0001);
    @(posedge core_clk);
    {setval_we, setval_num, setval_data} <= {1'b1, 9'h007, hd};
    @(posedge core_clk);
    setval_we <= 1'b0;
    // power loss, program mode, run start, interlock reset
    pulse(6'h08);
    pulse(6'h02);
    pulse(6'h04);
    pulse(6'h01);
    rd(2'h0, 1'b0, 9'h063, hd);
    rd(2'h2, 1'b0, 9'h00a, 16'h0000);
    rd(2'h1, 1'b0, 9'h003, 16'h0000);
    rd(2'h1, 1'b0, 9'h1ff, pd);
    check(setval_rdata, hd);
    // branch bit set once per block; reuse, range and misuse refused
    pulse(6'h10);
    acc(2'h3, 1'b1, 1'b1, 9'h002, 4'h0, 16'h0001);
    acc(2'h3, 1'b1, 1'b1, 9'h002, 4'h0, 16'h0000, 1'b1);
    acc(2'h3, 1'b1, 1'b1, 9'h008, 4'h0, 16'h0000, 1'b1);
    acc_is_load_out <= 1'b0;
    acc(2'h3, 1'b1, 1'b1, 9'h002, 4'h0, 16'h0000, 1'b1);
    acc_is_load_out <= 1'b1;
    rd(2'h3, 1'b1, 9'h002, 16'h0001);
    // block ranges per unit model, a non-decimal number, no unit
    cda_peer_i.mount_unit(1'b1, 1'b0);
    fil(16'h0999, 1'b1);
    fil(16'h1000, 1'b0);
    cda_peer_i.mount_unit(1'b1, 1'b1);
    fil(16'h1999, 1'b1);
    fil(16'h2000, 1'b0);
    fil(16'h00a0, 1'b0);
    cda_peer_i.mount_unit(1'b0, 1'b1);
    fil(16'h0001, 1'b0);
    for (int t = 0; t < 4; t++) begin
      mem_unit_type <= t[1:0];
      repeat (3) @(posedge core_clk);
      check(prog_words, 16'h2000 * (t + 1));
    end
    // second definition of timer 3 is flagged until a new check
    def(9'h003, 1'b1);
    repeat (2) @(posedge core_clk);
    check(check_error, 1'b1);
    pulse(6'h20);
    repeat (2) @(posedge core_clk);
    check(check_error, 1'b0);
    repeat (4) @(posedge core_clk);
    check(rq.size() + fq.size() + eq.size(), 0);
    give_verdict;
  end
endmodule // testbench
